// ==== core/aocc_defs.vh ====
`ifndef AOCC_DEFS_VH
`define AOCC_DEFS_VH
// Register addresses of the compensation bank (7-bit register space).
`define AOCC_ADDR_COMP_CONTROL 7'h36
`define AOCC_ADDR_TARGET_CFG 7'h37
`define AOCC_ADDR_FILT_X 7'h38
`define AOCC_ADDR_FILT_Y 7'h39
`define AOCC_ADDR_FILT_Z 7'h3A
`define AOCC_ADDR_RAW_X 7'h3B
`define AOCC_ADDR_RAW_Y 7'h3C
`define AOCC_ADDR_RAW_Z 7'h3D
`define AOCC_ADDR_SPARE_A 7'h3E
`define AOCC_ADDR_SPARE_B 7'h3F
`define AOCC_ADDR_NVM_CTRL 7'h33
// Field positions in the compensation control register.
`define AOCC_CTL_CLEAR_BIT 7
`define AOCC_CTL_AXIS_HI 6
`define AOCC_CTL_AXIS_LO 5
`define AOCC_CTL_READY_BIT 4
`define AOCC_CTL_SLOW_Z_BIT 2
`define AOCC_CTL_SLOW_Y_BIT 1
`define AOCC_CTL_SLOW_X_BIT 0
// Field positions in the target configuration register.
`define AOCC_CFG_WINDOW_BIT 0
// Image reload bit in the memory control register.
`define AOCC_NVM_LOAD_BIT 3
// Fast axis selection codes.
`define AOCC_AXIS_NONE 2'h0
`define AOCC_AXIS_X 2'h1
`define AOCC_AXIS_Y 2'h2
`define AOCC_AXIS_Z 2'h3
// Target codes.
`define AOCC_TGT_PLUS1G 2'h1
`define AOCC_TGT_MINUS1G 2'h2
// One g in acceleration sample counts (8-bit sample scale).
`define AOCC_ONE_G 8'h40
// Sample windows for slow compensation.
`define AOCC_WIN_SHORT 5'h08
`define AOCC_WIN_LONG 5'h10
// Number of image registers and reset values.
`define AOCC_IMAGE_COUNT 4'h8
// Store model contents: byte i holds this base value plus i (arbitrary value).
`define AOCC_NVM_BASE 8'hA5
`define AOCC_CTL_RESET 8'h00
`define AOCC_CFG_RESET 8'h00
`endif

// ==== core/aocc_nvm_store.v ====
`timescale 1ns/1ps
`include "aocc_defs.vh"
// Small non-volatile store model: eight bytes, registered read data.
module aocc_nvm_store (
   // Clock.
   input wire clk_in,
   // Read port.
   input wire [2:0] rd_addr_in,
   output reg [7:0] rd_data_out
);
   // Store contents; stands in for the programmed array.
   reg [7:0] mem_r [0:7];
   integer i;

   // Each byte holds its own value so that a reload that lands a byte at
   // the wrong index shows up; a real array would hold programmed values.
   initial begin
      for (i = 0; i < 8; i = i + 1) begin
         mem_r[i] = `AOCC_NVM_BASE + i[7:0];
      end
   end

   // Read data is registered, so data arrive one cycle after the address.
   always @(posedge clk_in) begin
      rd_data_out <= mem_r[rd_addr_in];
   end
endmodule // aocc_nvm_store

// ==== core/aocc_top.v ====
`timescale 1ns/1ps
`include "aocc_defs.vh"
module aocc_top (
   // Clock and reset.
   input wire clk_in,
   input wire sys_rst_in,
   // Register access from the serial host interface.
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [6:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   // Acceleration samples, signed, with a strobe per new sample set.
   input wire sample_valid_in,
   input wire [7:0] filt_x_in,
   input wire [7:0] filt_y_in,
   input wire [7:0] filt_z_in,
   input wire [7:0] raw_x_in,
   input wire [7:0] raw_y_in,
   input wire [7:0] raw_z_in,
   // Compensated samples.
   output reg comp_valid_out,
   output reg [7:0] filt_x_out,
   output reg [7:0] filt_y_out,
   output reg [7:0] filt_z_out,
   output reg [7:0] raw_x_out,
   output reg [7:0] raw_y_out,
   output reg [7:0] raw_z_out
);
   // Image registers: 0..2 filtered, 3..5 raw, 6..7 spare.
   reg [7:0] img_r [0:7];
   reg [7:0] img_nxt [0:7];
   // Control fields.
   reg [1:0] fast_axis_r;
   reg slow_comp_enable_xaxis;
   reg slow_comp_enable_yaxis;
   reg slow_comp_enable_zaxis;
   reg [7:0] target_cfg_r;
   // Reload sequencer: index into the store and busy flag.
   reg load_busy_r;
   reg [3:0] load_idx_r;
   wire [7:0] nvm_data;
   // Slow compensation sample counter; it counts samples, not clocks.
   reg [4:0] win_cnt_r;
   // Loop index of the next-state logic.
   integer k;
   // Loop index of the image register process, kept apart so that each
   // process drives a variable of its own.
   integer j;

   aocc_nvm_store u_store (
      .clk_in(clk_in),
      .rd_addr_in(load_idx_r[2:0]),
      .rd_data_out(nvm_data)
   );

   // Write strobes by address.
   wire wr_ctl = reg_wr_in && (reg_addr_in == `AOCC_ADDR_COMP_CONTROL);
   wire wr_cfg = reg_wr_in && (reg_addr_in == `AOCC_ADDR_TARGET_CFG);
   wire wr_nvm = reg_wr_in && (reg_addr_in == `AOCC_ADDR_NVM_CTRL);
   wire clear_cmd = wr_ctl && reg_wdata_in[`AOCC_CTL_CLEAR_BIT];
   wire [2:0] slow_en = {slow_comp_enable_zaxis, slow_comp_enable_yaxis, slow_comp_enable_xaxis};
   // Window length; one comparison is made, on the last sample, per this many samples.
   wire [4:0] win_len = target_cfg_r[`AOCC_CFG_WINDOW_BIT] ? `AOCC_WIN_LONG : `AOCC_WIN_SHORT;
   wire win_end = sample_valid_in && (win_cnt_r == win_len - 5'h01);
   // Image index of the axis under fast compensation (0..2 for x..z).
   // Only meaningful while the axis field is nonzero; three bits wide so
   // that the raw copy at index plus three cannot wrap.
   wire [2:0] fast_idx = {1'b0, fast_axis_r} - 3'h1;

   // Target value in sample counts for an axis code.
   function [7:0] tgt_val;
      input [1:0] code;
      begin
         if (code == `AOCC_TGT_PLUS1G) begin
            tgt_val = `AOCC_ONE_G;
         end else if (code == `AOCC_TGT_MINUS1G) begin
            tgt_val = 8'h00 - `AOCC_ONE_G;
         end else begin
            tgt_val = 8'h00;
         end
      end
   endfunction

   // Compensation step: moves the value one count so the compensated
   // sample approaches the target. A single step per window keeps the
   // loop slow and limits what one noisy sample can do to one count.
   function [7:0] step_toward;
      input [7:0] comp;
      input [7:0] sample;
      input [7:0] target;
      reg [7:0] sum;
      begin
         sum = sample + comp;
         if ($signed(sum) > $signed(target)) begin
            step_toward = comp - 8'h01;
         end else if ($signed(sum) < $signed(target)) begin
            step_toward = comp + 8'h01;
         end else begin
            step_toward = comp;
         end
      end
   endfunction

   // Sample of axis a (0..2) from the filtered path. The samples come in
   // as arguments because an always @* block does not see signals that a
   // function reads from the module scope, which would leave the merge
   // logic stale when only a sample input moves.
   function [7:0] filt_sel;
      input [1:0] a;
      input [7:0] fx;
      input [7:0] fy;
      input [7:0] fz;
      begin
         if (a == 2'h0) begin
            filt_sel = fx;
         end else if (a == 2'h1) begin
            filt_sel = fy;
         end else begin
            filt_sel = fz;
         end
      end
   endfunction

   // Next image values: software, clear, algorithms and reload merge here.
   // Priority, highest first: reload data, clear, software write, algorithms.
   always @* begin
      for (k = 0; k < 8; k = k + 1) begin
         img_nxt[k] = img_r[k];
      end
      // Slow compensation adjusts both paths of an enabled axis at window end.
      if (win_end) begin
         for (k = 0; k < 3; k = k + 1) begin
            if (slow_en[k]) begin
               // One count per window, judged on the filtered sample.
               img_nxt[k] = step_toward(img_r[k], filt_sel(k[1:0], filt_x_in, filt_y_in, filt_z_in),
                  tgt_val(target_cfg_r[2*k+2 -: 2]));
               img_nxt[k+3] = img_nxt[k];
            end
         end
      end
      // Fast compensation sets the value in one sample so the axis hits target.
      // Filtered and raw images of the axis take the same value.
      if (fast_axis_r != `AOCC_AXIS_NONE && sample_valid_in) begin
         img_nxt[fast_idx] = tgt_val(target_cfg_r[2*fast_idx+2 -: 2])
            - filt_sel(fast_idx[1:0], filt_x_in, filt_y_in, filt_z_in);
         img_nxt[fast_idx + 3'h3] = img_nxt[fast_idx];
      end
      // Direct software writes into the image window.
      if (reg_wr_in && reg_addr_in >= `AOCC_ADDR_FILT_X && reg_addr_in <= `AOCC_ADDR_SPARE_B) begin
         img_nxt[reg_addr_in[2:0]] = reg_wdata_in;
      end
      // Clear covers the six compensation images only; the spares keep theirs.
      if (clear_cmd) begin
         for (k = 0; k < 6; k = k + 1) begin
            img_nxt[k] = 8'h00;
         end
      end
      // Store data for index idx-1 arrives now because the read is registered.
      if (load_busy_r && load_idx_r != 4'h0) begin
         img_nxt[load_idx_r[2:0] - 3'h1] = nvm_data;
      end
   end

   // Image register update; reset leaves zeros until the reload fills them.
   // All merging happens in the next-state logic, so this stays a plain copy.
   always @(posedge clk_in) begin
      for (j = 0; j < 8; j = j + 1) begin
         if (sys_rst_in) begin
            img_r[j] <= 8'h00;
         end else begin
            img_r[j] <= img_nxt[j];
         end
      end
   end

   // Reload sequencer: starts at every reset and on software request.
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         load_busy_r <= 1'b1;
         load_idx_r <= 4'h0;
      end else if (load_busy_r) begin
         // Index eight is the cycle in which the last byte lands, so the
         // busy flag drops only once every image holds its stored value.
         if (load_idx_r == `AOCC_IMAGE_COUNT) begin
            load_busy_r <= 1'b0;
            load_idx_r <= 4'h0;
         end else begin
            // Step the store address; its data follow one cycle later.
            load_idx_r <= load_idx_r + 4'h1;
         end
      end else if (wr_nvm && reg_wdata_in[`AOCC_NVM_LOAD_BIT]) begin
         // A request while busy is not taken; the run in progress already
         // copies the whole store.
         load_busy_r <= 1'b1;
         load_idx_r <= 4'h0;
      end
   end

   // Control register fields. The clear bit is never stored, so it reads zero.
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         fast_axis_r <= `AOCC_AXIS_NONE;
         slow_comp_enable_xaxis <= 1'b0;
         slow_comp_enable_yaxis <= 1'b0;
         slow_comp_enable_zaxis <= 1'b0;
         target_cfg_r <= `AOCC_CFG_RESET;
      end else begin
         if (wr_ctl) begin
            slow_comp_enable_xaxis <= reg_wdata_in[`AOCC_CTL_SLOW_X_BIT];
            slow_comp_enable_yaxis <= reg_wdata_in[`AOCC_CTL_SLOW_Y_BIT];
            slow_comp_enable_zaxis <= reg_wdata_in[`AOCC_CTL_SLOW_Z_BIT];
         end
         // A new selection is taken only while idle; a run in progress holds.
         // The run ends with the sample that sets the compensation values,
         // so the field and the ready flag change on that same edge.
         if (fast_axis_r != `AOCC_AXIS_NONE) begin
            if (sample_valid_in) begin
               fast_axis_r <= `AOCC_AXIS_NONE;
            end
         end else if (wr_ctl) begin
            fast_axis_r <= reg_wdata_in[`AOCC_CTL_AXIS_HI:`AOCC_CTL_AXIS_LO];
         end
         if (wr_cfg) begin
            target_cfg_r <= {1'b0, reg_wdata_in[6:0]};
         end
      end
   end

   // Window counter, shared by all axes so windows stay aligned.
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         win_cnt_r <= 5'h00;
      end else if (slow_en == 3'h0) begin
         // With every axis off the window restarts, so the first window
         // after an enable is always a full one.
         win_cnt_r <= 5'h00;
      end else if (sample_valid_in) begin
         win_cnt_r <= win_end ? 5'h00 : win_cnt_r + 5'h01;
      end
   end

   // Compensated output path, one cycle behind the input strobe.
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         comp_valid_out <= 1'b0;
         filt_x_out <= 8'h00;
         filt_y_out <= 8'h00;
         filt_z_out <= 8'h00;
         raw_x_out <= 8'h00;
         raw_y_out <= 8'h00;
         raw_z_out <= 8'h00;
      end else begin
         comp_valid_out <= sample_valid_in;
         // Sums wrap modulo 256 like the samples; the outputs hold between
         // strobes so a late reader still sees one consistent sample set.
         if (sample_valid_in) begin
            filt_x_out <= filt_x_in + img_r[0];
            filt_y_out <= filt_y_in + img_r[1];
            filt_z_out <= filt_z_in + img_r[2];
            raw_x_out <= raw_x_in + img_r[3];
            raw_y_out <= raw_y_in + img_r[4];
            raw_z_out <= raw_z_in + img_r[5];
         end
      end
   end

   // Registered read data; unmapped addresses read zero.
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         // The clear bit and the reserved bit always read zero; the ready
         // flag is derived from the axis field, never stored on its own.
         if (reg_addr_in == `AOCC_ADDR_COMP_CONTROL) begin
            reg_rdata_out <= {1'b0, fast_axis_r, (fast_axis_r == `AOCC_AXIS_NONE), 1'b0, slow_en};
         end else if (reg_addr_in == `AOCC_ADDR_TARGET_CFG) begin
            reg_rdata_out <= target_cfg_r;
         end else if (reg_addr_in == `AOCC_ADDR_NVM_CTRL) begin
            // Only the reload bit is built; the other control bits read zero.
            reg_rdata_out <= {4'h0, load_busy_r, 3'h0};
         end else if (reg_addr_in >= `AOCC_ADDR_FILT_X && reg_addr_in <= `AOCC_ADDR_SPARE_B) begin
            reg_rdata_out <= img_r[reg_addr_in[2:0]];
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end
endmodule // aocc_top

// ==== test/aocc_props.sv ====
`timescale 1ns/1ps
// Port-level checks for the compensation bank.
module aocc_props (
   // Clock and reset.
   input wire clk_in,
   input wire sys_rst_in,
   // Register access.
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [6:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   // Samples.
   input wire sample_valid_in,
   input wire [7:0] filt_x_in,
   input wire comp_valid_out,
   input wire [7:0] filt_x_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   property p_ready;
      reg_rd_in && reg_addr_in == 7'h36 |=> reg_rdata_out[4] == (reg_rdata_out[6:5] == 2'h0);
   endproperty
   a_ready: assert property (p_ready) else $error("ready flag wrong");
   property p_clr;
      reg_rd_in && reg_addr_in == 7'h36 |=> !reg_rdata_out[7] && !reg_rdata_out[3];
   endproperty
   a_clr: assert property (p_clr) else $error("clear bit not zero");
   property p_nvm;
      reg_rd_in && reg_addr_in == 7'h33 |=> (reg_rdata_out & 8'hF7) == 8'h00;
   endproperty
   a_nvm: assert property (p_nvm) else $error("reload reg bits");
   property p_cv;
      sample_valid_in |=> comp_valid_out;
   endproperty
   a_cv: assert property (p_cv) else $error("no output strobe");
   property p_cv0;
      !sample_valid_in |=> !comp_valid_out;
   endproperty
   a_cv0: assert property (p_cv0) else $error("extra output strobe");
   property p_hold;
      !comp_valid_out |-> $stable(filt_x_out);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved");
   property p_sum0;
      (reg_wr_in && reg_addr_in == 7'h36 && reg_wdata_in == 8'h80) ##[1:2] (sample_valid_in && !reg_wr_in)
         |=> filt_x_out == $past(filt_x_in);
   endproperty
   a_sum0: assert property (p_sum0) else $error("offset not cleared");
   property p_rdhold;
      !reg_rd_in |=> $stable(reg_rdata_out);
   endproperty
   a_rdhold: assert property (p_rdhold) else $error("read data moved");
   c_fast: cover property (reg_wr_in && reg_addr_in == 7'h36 && reg_wdata_in[6:5] != 2'h0);
   c_clear: cover property (reg_wr_in && reg_addr_in == 7'h36 && reg_wdata_in[7]);
   c_samp: cover property (sample_valid_in ##1 comp_valid_out);
endmodule // aocc_props

// ==== test/test_aocc_top.sv ====
`timescale 1ns/1ps
`include "aocc_defs.vh"
// Bench: drives on falling edges, so every request is settled at the rising edge.
module test_aocc_top;
   reg clk_in = 1'b0;
   reg sys_rst_in = 1'b1;
   reg reg_wr_in = 1'b0;
   reg reg_rd_in = 1'b0;
   reg [6:0] reg_addr_in = 7'h00;
   reg [7:0] reg_wdata_in = 8'h00;
   reg sample_valid_in = 1'b0;
   reg [7:0] smp = 8'h00; // Axis i sees smp + i, so crossed lanes show up.
   reg [7:0] cm [0:7]; // Expected image contents from 0x38 upward.
   wire [7:0] rdo;
   wire [7:0] q [0:5];
   wire cv;
   integer n_fail = 0;
   integer n_tests = 0;
   always #5 clk_in = ~clk_in;
   aocc_top u_aocc_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(rdo), .sample_valid_in(sample_valid_in), .filt_x_in(smp),
      .filt_y_in(smp + 8'h01), .filt_z_in(smp + 8'h02), .raw_x_in(smp + 8'h03),
      .raw_y_in(smp + 8'h04), .raw_z_in(smp + 8'h05), .comp_valid_out(cv),
      .filt_x_out(q[0]), .filt_y_out(q[1]), .filt_z_out(q[2]), .raw_x_out(q[3]),
      .raw_y_out(q[4]), .raw_z_out(q[5]));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      begin
         @(negedge clk_in);
         reg_wr_in = 1'b1;
         reg_addr_in = a;
         reg_wdata_in = d;
         @(negedge clk_in);
         reg_wr_in = 1'b0;
      end
   endtask
   // Read data is registered, so it is judged one cycle after the strobe.
   task rdc(input [6:0] a, input [7:0] e);
      begin
         @(negedge clk_in);
         reg_rd_in = 1'b1;
         reg_addr_in = a;
         @(negedge clk_in);
         reg_rd_in = 1'b0;
         chk(rdo, e);
      end
   endtask
   task chkimg;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1)
            rdc(7'h38 + i[6:0], cm[i]);
      end
   endtask
   task samp(input [7:0] v, input ck);
      integer i;
      begin
         @(negedge clk_in);
         smp = v;
         sample_valid_in = 1'b1;
         @(negedge clk_in);
         sample_valid_in = 1'b0;
         if (ck) begin
            chk({7'h00, cv}, 8'h01);
            for (i = 0; i < 6; i = i + 1)
               chk(q[i], v + i[7:0] + cm[i]);
         end
      end
   endtask
   task t_reset;
      integer i;
      begin
         rdc(7'h33, 8'h08);
         repeat (10) @(negedge clk_in);
         rdc(7'h33, 8'h00);
         rdc(7'h36, 8'h10);
         rdc(7'h37, 8'h00);
         rdc(7'h35, 8'h00);
         // Store byte i holds the base value plus i.
         for (i = 0; i < 8; i = i + 1)
            cm[i] = `AOCC_NVM_BASE + i[7:0];
         chkimg;
      end
   endtask
   task t_rw;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            cm[i] = 8'h11 * i[7:0] + 8'h11;
            wr(7'h38 + i[6:0], cm[i]);
         end
         chkimg;
         samp(8'h20, 1'b1);
      end
   endtask
   // Clear must spare the two spare images.
   task t_clear;
      integer i;
      begin
         wr(7'h36, 8'h80);
         for (i = 0; i < 6; i = i + 1)
            cm[i] = 8'h00;
         samp(8'h30, 1'b1);
         rdc(7'h36, 8'h10);
         chkimg;
      end
   endtask
   task t_reload;
      integer i;
      begin
         wr(7'h33, 8'h08);
         rdc(7'h33, 8'h08);
         repeat (10) @(negedge clk_in);
         rdc(7'h33, 8'h00);
         for (i = 0; i < 8; i = i + 1)
            cm[i] = `AOCC_NVM_BASE + i[7:0];
         chkimg;
      end
   endtask
   // Targets: x +1 g, y -1 g, z code 11b (0 g); one g is 0x40 counts.
   task t_fast;
      integer a;
      reg [7:0] e;
      begin
         wr(7'h37, 8'h72);
         rdc(7'h37, 8'h72);
         for (a = 1; a < 4; a = a + 1) begin
            wr(7'h36, {1'b0, a[1:0], 5'h00});
            wr(7'h36, {1'b0, ~a[1:0], 5'h00});
            rdc(7'h36, {1'b0, a[1:0], 5'h00});
            e = (a == 1) ? 8'h40 : ((a == 2) ? 8'hC0 : 8'h00);
            e = e - 8'h0F - a[7:0];
            samp(8'h10, 1'b0);
            rdc(7'h36, 8'h10);
            rdc(7'h37 + a[6:0], e);
            rdc(7'h3A + a[6:0], e);
         end
      end
   endtask
   // A positive x reading against a 0 g target walks the offset down.
   task t_slow;
      begin
         wr(7'h36, 8'h80);
         wr(7'h37, 8'h00);
         wr(7'h36, 8'h01);
         rdc(7'h36, 8'h11);
         repeat (7) samp(8'h03, 1'b0);
         rdc(7'h38, 8'h00);
         samp(8'h03, 1'b0);
         rdc(7'h38, 8'hFF);
         rdc(7'h3B, 8'hFF);
         rdc(7'h39, 8'h00);
         wr(7'h37, 8'h01);
         repeat (15) samp(8'h03, 1'b0);
         rdc(7'h38, 8'hFF);
         samp(8'h03, 1'b0);
         rdc(7'h38, 8'hFE);
      end
   endtask
   task results;
      begin
         if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      repeat (12) @(negedge clk_in);
      sys_rst_in = 1'b0;
      t_reset;
      t_rw;
      t_clear;
      t_reload;
      t_fast;
      t_slow;
      results;
   end
   // The run needs well under 1000 cycles.
   initial begin
      #100000;
      n_fail = n_fail + 1;
      results;
   end
endmodule // test_aocc_top
bind aocc_top aocc_props u_aocc_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
   .filt_x_in(filt_x_in), .comp_valid_out(comp_valid_out), .filt_x_out(filt_x_out));
